// ### include/dma_usage_pkg.sv
// package: shared constants and types of the dma channel controller
// assumes bus clock = core_clk; peripheral clock derived as a whole ratio of it
package dma_usage_pkg;
	localparam int NUM_CH = 4;
	localparam int CNT_W = 16;
	localparam int NUM_TIMER_BITS = 5;
	// request source codes per channel
	localparam logic [2:0] SRC_AUTO = 3'h0;
	localparam logic [2:0] SRC_EXT = 3'h1;
	localparam logic [2:0] SRC_SERIAL_TX = 3'h2;
	localparam logic [2:0] SRC_SERIAL_RX = 3'h3;
	localparam logic [2:0] SRC_ADC = 3'h4;
	localparam logic [2:0] SRC_TIMER = 3'h5;
	// internal-to-bus clock ratio codes
	localparam logic [1:0] RATIO_1_1 = 2'h0;
	localparam logic [1:0] RATIO_1_2 = 2'h1;
	localparam logic [1:0] RATIO_1_3 = 2'h2;
	localparam logic [1:0] RATIO_1_4 = 2'h3;
	// on-chip ram access cycles, in bus cycles
	localparam logic [1:0] RAM_RD_1_1 = 2'h3;
	localparam logic [1:0] RAM_WR_1_1 = 2'h3;
	localparam logic [1:0] RAM_RD_1_2 = 2'h2;
	localparam logic [1:0] RAM_WR_1_2 = 2'h1;
	localparam logic [1:0] RAM_RD_1_4 = 2'h1;
	localparam logic [1:0] RAM_WR_1_4 = 2'h1;
	localparam logic [1:0] EXT_ACCESS_CYC = 2'h1;
	// decision latencies: bus cycles and peripheral cycles
	localparam int TRANSFER_REQUEST_IN_DECIDE_BCYC = 3;
	localparam int PERIPH_DECIDE_PCYC = 1;
	localparam int NMI_STOP_BCYC = 1;
	localparam int NMI_STOP_PCYC = 3;
	localparam int PCLK_DIV_DEFAULT = 2;
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_WAIT_BUS = 5'b00010,
		ST_READ = 5'b00100,
		ST_WRITE = 5'b01000,
		ST_RELEASE = 5'b10000
	} engine_state_type;
endpackage

// ### include/req_if.sv
// interface: pending requests from the request latch to the transfer engine
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface req_if;
	import dma_usage_pkg::*;
	logic [NUM_CH-1:0] pending;
	logic [NUM_CH-1:0] level_ext;
	logic [NUM_CH-1:0] accept;
	modport latch (output pending, output level_ext, input accept);
	modport engine (input pending, input level_ext, output accept);
endinterface

// ### src/request_latch.sv
// request latch: decides and holds per-channel transfer requests
// assumes request pins and peripheral irqs are synchronous to core_clk
`timescale 1ns/1ps
module request_latch
	import dma_usage_pkg::*;
#(
	parameter int PCLK_DIV = PCLK_DIV_DEFAULT
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [NUM_CH*3-1:0] ch_source,
	input wire logic [NUM_CH-1:0] transfer_request_in,
	input wire logic serial_tx_irq,
	input wire logic serial_rx_irq,
	input wire logic adc_end_irq,
	input wire logic [NUM_CH-1:0] timer_req,
	req_if.latch req
);
	localparam int PDEC = PERIPH_DECIDE_PCYC * PCLK_DIV;
	logic [TRANSFER_REQUEST_IN_DECIDE_BCYC-1:0] ext_pipe [NUM_CH];
	logic [NUM_CH-1:0] held;
	logic [7:0] decide_cnt [NUM_CH];
	logic [NUM_CH-1:0] periph_hit;
	logic [NUM_CH-1:0] is_ext;

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		wire logic [2:0] src = ch_source[c*3 +: 3];
		// irqs are captured whatever the channel enable says, so a stale
		// irq still becomes a transfer later
		assign periph_hit[c] = (src == SRC_SERIAL_TX && serial_tx_irq) ||
			(src == SRC_SERIAL_RX && serial_rx_irq) ||
			(src == SRC_ADC && adc_end_irq) ||
			(src == SRC_TIMER && timer_req[c]) ||
			(src == SRC_AUTO); // RQ13
		assign is_ext[c] = (src == SRC_EXT);
		assign req.level_ext[c] = ext_pipe[c][TRANSFER_REQUEST_IN_DECIDE_BCYC-1];
		assign req.pending[c] = is_ext[c] ? ext_pipe[c][TRANSFER_REQUEST_IN_DECIDE_BCYC-1] :
			(held[c] && decide_cnt[c] == 8'h00);

		// request pin decided after three bus cycles
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				ext_pipe[c] <= '0;
			end else begin
				ext_pipe[c] <= {ext_pipe[c][TRANSFER_REQUEST_IN_DECIDE_BCYC-2:0], transfer_request_in[c]}; // RQ12
			end
		end

		// held request: a new irq wins over the accept in the same cycle
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				held[c] <= 1'b0;
			end else begin
				held[c] <= (held[c] && !req.accept[c]) || (periph_hit[c] && !is_ext[c]); // RQ13
			end
		end

		// one peripheral cycle before a held request counts
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				decide_cnt[c] <= 8'h00;
			end else if (periph_hit[c] && !held[c]) begin
				decide_cnt[c] <= 8'(PDEC - 1); // RQ12
			end else if (decide_cnt[c] != 8'h00) begin
				decide_cnt[c] <= decide_cnt[c] - 8'h01;
			end
		end
	end
endmodule

// ### src/dma_channel_ctrl.sv
// four-channel dma activation and transfer engine (top)
// assumes all config ports are stable while the channel enable is high
// Notes on behaviour
// RQ1 - acknowledge only while this engine owns bus
// RQ2 - software avoids mixed burst/steal acknowledge hazard
// RQ3 - no 1:1/3 or 1:1/4 peripheral ratios
// RQ4 - disabled after reset until standby cancelled
// RQ5 - no standby entry while transfers active
// RQ6 - no transfers targeting controller registers
// RQ7 - serial transmit-end flag is not transfer end
// RQ8 - clear enable before changing channel control
// RQ9 - one on-chip source per channel only
// RQ10 - requests only after channel setup done
// RQ11 - nmi beats activation, sets nmi flag
// RQ12 - nmi stop, pin, peripheral decision latencies
// RQ13 - peripheral irqs latched as held requests
// RQ14 - enable serial-tx channel after tx-empty irq
// RQ15 - receive/adc flags cleared only by dma
// RQ16 - on-chip ram cycles follow clock ratio
// RQ17 - timer burst needs its priority bit set
// RQ18 - preferential bus access setting honoured
// RQ19 - burst holds bus; level pin may release
`timescale 1ns/1ps
module dma_channel_ctrl
	import dma_usage_pkg::*;
#(
	parameter int PCLK_DIV = PCLK_DIV_DEFAULT
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic standby_cancel,
	input wire logic master_enable,
	input wire logic [NUM_CH-1:0] channel_enable_bit,
	input wire logic [NUM_CH-1:0] ch_burst,
	input wire logic [NUM_CH-1:0] ch_wr_ack_en,
	input wire logic [NUM_CH-1:0] ch_ram_target,
	input wire logic [NUM_CH*3-1:0] ch_source,
	input wire logic [NUM_CH*CNT_W-1:0] ch_count,
	input wire logic [NUM_CH-1:0] transfer_end_clear,
	input wire logic [1:0] clk_ratio,
	input wire logic [NUM_TIMER_BITS-1:0] timer_burst_priority_bits,
	input wire logic bus_pref_enable,
	input wire logic [NUM_CH-1:0] transfer_request_in,
	input wire logic serial_tx_irq,
	input wire logic serial_rx_irq,
	input wire logic adc_end_irq,
	input wire logic [NUM_CH-1:0] timer_req,
	input wire logic nmi_in,
	input wire logic nmi_flag_clear,
	input wire logic bus_grant,
	output logic bus_request,
	output logic bus_priority_req,
	output logic reg_access_enable,
	output logic [NUM_CH-1:0] transfer_ack_out,
	output logic [NUM_CH-1:0] transfer_end_flag,
	output logic nmi_flag,
	output logic read_active,
	output logic write_active,
	output logic [1:0] active_channel
);
	localparam logic [7:0] NMI_STOP_CYC = 8'(NMI_STOP_BCYC + NMI_STOP_PCYC * PCLK_DIV);

	req_if req ();
	engine_state_type state, next_state;
	logic standby;
	logic [1:0] cur;
	logic [1:0] winner;
	logic [1:0] cyc_left;
	logic [7:0] nmi_cnt;
	logic [NUM_CH-1:0] en_prev;
	logic [CNT_W-1:0] remaining [NUM_CH];

	// access cycles for one read or write of the current channel
	function automatic logic [1:0] access_cycles(input logic ram, input logic [1:0] ratio,
		input logic wr);
		logic [1:0] n;
		n = EXT_ACCESS_CYC;
		if (ram) begin
			unique case (ratio)
				RATIO_1_1: n = wr ? RAM_WR_1_1 : RAM_RD_1_1;
				RATIO_1_2, RATIO_1_3: n = wr ? RAM_WR_1_2 : RAM_RD_1_2;
				RATIO_1_4: n = wr ? RAM_WR_1_4 : RAM_RD_1_4;
			endcase
		end
		return n;
	endfunction

	request_latch #(.PCLK_DIV(PCLK_DIV)) u_latch (
		.core_clk(core_clk),
		.rst(rst),
		.ch_source(ch_source),
		.transfer_request_in(transfer_request_in),
		.serial_tx_irq(serial_tx_irq),
		.serial_rx_irq(serial_rx_irq),
		.adc_end_irq(adc_end_irq),
		.timer_req(timer_req),
		.req(req.latch)
	);

	// eligibility and fixed priority, channel 0 highest
	wire logic [NUM_CH-1:0] eligible = channel_enable_bit & ~transfer_end_flag & req.pending;
	wire logic run_ok = master_enable && !standby && !nmi_flag;
	wire logic start_ok = run_ok && !nmi_in && (eligible != '0); // RQ11
	assign winner = eligible[0] ? 2'h0 : eligible[1] ? 2'h1 : eligible[2] ? 2'h2 : 2'h3;
	wire logic [2:0] cur_src = ch_source[cur*3 +: 3];
	wire logic cur_burst = ch_burst[cur];
	wire logic last_unit = (remaining[cur] == {{(CNT_W-1){1'b0}}, 1'b1});
	// level-sensed pin going idle ends a burst early
	wire logic pin_dropped = (cur_src == SRC_EXT) && !req.level_ext[cur]; // RQ19
	wire logic nmi_stop = (nmi_cnt == 8'h01);
	wire logic abort = nmi_stop || standby || !master_enable;
	wire logic unit_done = (state == ST_WRITE) && (cyc_left == 2'h0);
	wire logic [1:0] rd_cyc = access_cycles(ch_ram_target[cur], clk_ratio, 1'b0); // RQ16
	wire logic [1:0] wr_cyc = access_cycles(ch_ram_target[cur], clk_ratio, 1'b1); // RQ16
	wire logic timer_pref = (cur_src == SRC_TIMER) && cur_burst &&
		timer_burst_priority_bits[cur];

	// request handshake: bus held from request until release
	assign bus_request = (state == ST_WAIT_BUS) || (state == ST_READ) || (state == ST_WRITE);
	assign reg_access_enable = !standby; // RQ4
	assign req.accept = (state == ST_IDLE && start_ok) ? (NUM_CH'(1) << winner) : '0;

	// next state of the transfer engine
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: if (start_ok) next_state = ST_WAIT_BUS;
			ST_WAIT_BUS: begin
				if (abort) begin
					next_state = ST_RELEASE;
				end else if (bus_grant) begin
					next_state = ST_READ;
				end
			end
			ST_READ: begin
				if (abort) begin
					next_state = ST_RELEASE;
				end else if (cyc_left == 2'h0) begin
					next_state = ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (abort) begin
					next_state = ST_RELEASE;
				end else if (cyc_left == 2'h0) begin
					// burst keeps the bus until count ends or the pin drops
					next_state = (!cur_burst || last_unit || pin_dropped) ? ST_RELEASE :
						ST_READ; // RQ19
				end
			end
			ST_RELEASE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// state and channel registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			cur <= 2'h0;
		end else begin
			state <= next_state;
			if (state == ST_IDLE && start_ok) begin
				cur <= winner;
			end
		end
	end

	// access cycle counter, reloaded when entering a read or write
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cyc_left <= 2'h0;
		end else if (next_state == ST_READ && state != ST_READ) begin
			cyc_left <= rd_cyc - 2'h1;
		end else if (next_state == ST_WRITE && state != ST_WRITE) begin
			cyc_left <= wr_cyc - 2'h1;
		end else if (cyc_left != 2'h0) begin
			cyc_left <= cyc_left - 2'h1;
		end
	end

	// module standby: set by reset, cancelled by software
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			standby <= 1'b1;
		end else begin
			standby <= !standby_cancel; // RQ4
		end
	end

	// nmi: sticky flag, set wins over clear; stop decided after bus+3 pclk
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			nmi_flag <= 1'b0;
			nmi_cnt <= 8'h00;
		end else begin
			nmi_flag <= nmi_in || (nmi_flag && !nmi_flag_clear); // RQ11
			if (nmi_in && nmi_cnt == 8'h00) begin
				nmi_cnt <= NMI_STOP_CYC; // RQ12
			end else if (nmi_cnt != 8'h00) begin
				nmi_cnt <= nmi_cnt - 8'h01;
			end
		end
	end

	// per-channel count and end flag
	for (genvar c = 0; c < NUM_CH; c++) begin : g_cnt
		wire logic load = channel_enable_bit[c] && !en_prev[c];
		wire logic hit = unit_done && !abort && (cur == 2'(c));
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				remaining[c] <= '0;
				transfer_end_flag[c] <= 1'b0;
			end else begin
				if (load) begin
					remaining[c] <= ch_count[c*CNT_W +: CNT_W];
				end else if (hit) begin
					remaining[c] <= remaining[c] - {{(CNT_W-1){1'b0}}, 1'b1};
				end
				transfer_end_flag[c] <= (hit && last_unit) ||
					(transfer_end_flag[c] && !transfer_end_clear[c]);
			end
		end
	end

	// registered status and acknowledge outputs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			en_prev <= '0;
			transfer_ack_out <= '0;
			read_active <= 1'b0;
			write_active <= 1'b0;
			bus_priority_req <= 1'b0;
			active_channel <= 2'h0;
		end else begin
			en_prev <= channel_enable_bit;
			read_active <= (next_state == ST_READ);
			write_active <= (next_state == ST_WRITE);
			// ack only inside owned read/write cycles, never across a release
			transfer_ack_out <= ((next_state == ST_WRITE && ch_wr_ack_en[cur]) ||
				(next_state == ST_READ && !ch_wr_ack_en[cur])) ?
				(NUM_CH'(1) << cur) : '0; // RQ1
			bus_priority_req <= bus_request && (bus_pref_enable || timer_pref); // RQ18
			active_channel <= cur;
		end
	end
endmodule

// ### verif/dma_channel_ctrl_asserts.sv
// checker: port timing of the dma channel controller
// assumes bound into dma_channel_ctrl, one clock core_clk
`timescale 1ns/1ps
module dma_channel_ctrl_asserts
	import dma_usage_pkg::*;
#(
	parameter int PCLK_DIV = PCLK_DIV_DEFAULT
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic standby_cancel,
	input wire logic bus_pref_enable,
	input wire logic [1:0] clk_ratio,
	input wire logic [NUM_CH-1:0] ch_ram_target,
	input wire logic [NUM_CH-1:0] ch_wr_ack_en,
	input wire logic nmi_in,
	input wire logic bus_request,
	input wire logic bus_priority_req,
	input wire logic reg_access_enable,
	input wire logic [NUM_CH-1:0] transfer_ack_out,
	input wire logic nmi_flag,
	input wire logic read_active,
	input wire logic write_active,
	input wire logic [1:0] active_channel
);
	// nmi stop bound: one bus cycle, three peripheral cycles, one to drop
	localparam int NMI_MAX = NMI_STOP_BCYC + 1 + NMI_STOP_PCYC * PCLK_DIV;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// acknowledge only in an owned phase, of one channel, in the chosen phase
	ack_in_phase_a: assert property (transfer_ack_out != '0 |->
		(read_active || write_active) && $onehot(transfer_ack_out)) else $error("stray ack");
	ack_phase_sel_a: assert property (transfer_ack_out != '0 |->
		write_active == ch_wr_ack_en[active_channel]) else $error("ack in wrong phase");
	// registers stay shut until standby is cancelled
	reg_gate_a: assert property (reg_access_enable |-> $past(standby_cancel))
		else $error("register access while in standby");
	standby_exit_a: assert property ($rose(standby_cancel) |=> reg_access_enable)
		else $error("standby cancel not honoured");
	// nmi beats activation and stops a running transfer in time; bus_pref_enable raises bus_priority_req while bus is requested
	nmi_set_a: assert property (nmi_in |=> nmi_flag)
		else $error("nmi flag not set");
	nmi_no_start_a: assert property ((nmi_in || nmi_flag) && !bus_request |=> !bus_request)
		else $error("start despite nmi");
	nmi_stop_a: assert property (nmi_in && bus_request |-> ##[1:NMI_MAX] !bus_request)
		else $error("nmi stop too slow");
	bus_pref_a: assert property ($past(bus_request && bus_pref_enable) |-> bus_priority_req)
		else $error("preferential bus request missing");
	// on-chip ram read length at 1:1 and write length at the other ratios; an nmi stop may cut a read short
	ram_rd_len_a: assert property (disable iff (rst || nmi_flag)
		$rose(read_active) && clk_ratio == RATIO_1_1 &&
		ch_ram_target[active_channel] |-> read_active[*3] ##1 !read_active) else $error("ram read");
	ram_wr_len_a: assert property ($rose(write_active) && clk_ratio != RATIO_1_1 &&
		ch_ram_target[active_channel] |=> !write_active) else $error("ram write length");
endmodule

bind dma_channel_ctrl dma_channel_ctrl_asserts #(.PCLK_DIV(PCLK_DIV)) i_dma_channel_ctrl_asserts (.*);

// ### verif/bus_owner_model.sv
// partner: the other bus master, granting the bus promptly or late
// assumes the controller holds bus_request until it is done
`timescale 1ns/1ps
module bus_owner_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic bus_request,
	input wire logic slow,
	output logic bus_grant
);
	logic [2:0] wait_cnt;
	// slow mode stands for a master that finishes its own cycles first
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wait_cnt <= 3'h0;
			bus_grant <= 1'b0;
		end else if (!bus_request) begin
			wait_cnt <= 3'h0;
			bus_grant <= 1'b0;
		end else begin
			wait_cnt <= (wait_cnt == 3'h7) ? wait_cnt : wait_cnt + 3'h1;
			bus_grant <= !slow || wait_cnt >= 3'h3;
		end
	end
endmodule

// ### verif/test_dma_channel_ctrl.sv
// testbench: drives the dma channel controller through its control ports
// assumes bus_owner_model as the other bus master, PCLK_DIV of 2
`timescale 1ns/1ps
module test_dma_channel_ctrl;
	import dma_usage_pkg::*;
	localparam int PCLK = 2;
	logic core_clk, rst, standby_cancel, master_enable, bus_pref_enable, nmi_in, nmi_flag_clear;
	logic slow, bus_grant, bus_request, bus_priority_req, reg_access_enable, nmi_flag;
	logic read_active, write_active, serial_tx_irq, serial_rx_irq, adc_end_irq;
	logic [NUM_CH-1:0] channel_enable_bit, ch_burst, ch_wr_ack_en, ch_ram_target;
	logic [NUM_CH-1:0] transfer_end_clear, transfer_request_in, timer_req;
	logic [NUM_CH-1:0] transfer_ack_out, transfer_end_flag;
	logic [NUM_CH*3-1:0] ch_source;
	logic [NUM_CH*CNT_W-1:0] ch_count;
	logic [1:0] clk_ratio, active_channel;
	logic [NUM_TIMER_BITS-1:0] timer_burst_priority_bits;
	logic [3:0] irq_v;
	logic [15:0] n, k;
	logic [15:0] rd [4] = '{16'h3, 16'h2, 16'h2, 16'h1};
	logic [15:0] wr [4] = '{16'h3, 16'h1, 16'h1, 16'h1};
	int num_errors = 0;
	int comparisons = 0;
	// one pulse vector feeds the four on-chip request sources of channel 1
	assign {adc_end_irq, serial_rx_irq, serial_tx_irq} = irq_v[2:0];
	assign timer_req = {2'h0, irq_v[3], 1'b0};
	dma_channel_ctrl #(.PCLK_DIV(PCLK)) i_dma_channel_ctrl (.*);
	bus_owner_model i_bus_owner_model (.*);
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge core_clk);
	endtask
	// counts edges until bus_request reaches lvl; a hang ends the run
	task automatic wait_br(input logic lvl);
		n = 0;
		do begin
			@(posedge core_clk);
			#1 n++;
		end while (bus_request !== lvl && n < 99);
		if (bus_request !== lvl) begin
			num_errors++;
			tally_and_finish();
		end
	endtask
	task automatic wait_end(input int ch);
		k = 0;
		while (transfer_end_flag[ch] !== 1'b1 && k < 300) begin
			@(posedge core_clk);
			#1 k++;
		end
		chk(16'(transfer_end_flag[ch]), 16'h1);
		if (transfer_end_flag[ch] !== 1'b1) tally_and_finish();
	endtask
	// settings change only with the enables low
	task automatic setup(input int ch, input logic [2:0] src, input logic b, input logic [15:0] c);
		@(posedge core_clk);
		channel_enable_bit <= '0;
		ch_source[ch*3+:3] <= src;
		ch_burst[ch] <= b;
		ch_count[ch*CNT_W+:CNT_W] <= c;
		transfer_end_clear <= '1;
		@(posedge core_clk);
		transfer_end_clear <= '0;
	endtask
	task automatic go(input int ch);
		@(posedge core_clk);
		channel_enable_bit[ch] <= 1'b1;
	endtask
	task automatic nmi_clr();
		cyc(1);
		nmi_flag_clear <= 1'b1;
		cyc(1);
		nmi_flag_clear <= 1'b0;
	endtask
	initial begin
		{standby_cancel, master_enable, bus_pref_enable, nmi_in, nmi_flag_clear, slow} = '0;
		{channel_enable_bit, ch_burst, ch_wr_ack_en, ch_ram_target} = '0;
		{transfer_end_clear, transfer_request_in, ch_count} = '0;
		// idle pin source, so no channel starts with a stale held request
		ch_source = {NUM_CH{SRC_EXT}};
		{clk_ratio, timer_burst_priority_bits, irq_v} = '0;
		rst = 1'b1;
		cyc(4);
		rst <= 1'b0;
		// auto channel stays idle while in standby
		setup(0, SRC_AUTO, 1'b0, 16'h1);
		master_enable <= 1'b1;
		go(0);
		cyc(8);
		#1 chk(16'(bus_request), 16'h0);
		chk(16'(reg_access_enable), 16'h0);
		cyc(1);
		standby_cancel <= 1'b1;
		wait_br(1'b1);
		chk(16'(reg_access_enable), 16'h1);
		wait_end(0);
		// pin request decided in three bus cycles, bus request one later
		setup(0, SRC_EXT, 1'b0, 16'h1);
		go(0);
		slow <= 1'b1;
		cyc(1);
		transfer_request_in[0] <= 1'b1;
		wait_br(1'b1);
		chk(n, 16'(TRANSFER_REQUEST_IN_DECIDE_BCYC + 1));
		cyc(1);
		transfer_request_in[0] <= 1'b0;
		wait_end(0);
		// a pulse seen before enabling is held and starts a unit on its own
		for (int i = 0; i < 4; i++) begin
			setup(1, SRC_SERIAL_TX + 3'(i), 1'b0, 16'h2);
			irq_v <= 4'h1 << i;
			cyc(1);
			irq_v <= 4'h0;
			go(1);
			wait_br(1'b1);
			chk(16'(bus_request), 16'h1);
			wait_br(1'b0);
			cyc(1);
			irq_v <= 4'h1 << i;
			cyc(1);
			irq_v <= 4'h0;
			wait_br(1'b1);
			chk(n, 16'(PERIPH_DECIDE_PCYC * PCLK));
			wait_end(1);
		end
		// nmi in the activation cycle wins
		setup(0, SRC_AUTO, 1'b0, 16'h1);
		go(0);
		nmi_in <= 1'b1;
		cyc(1);
		nmi_in <= 1'b0;
		cyc(8);
		#1 chk(16'(nmi_flag), 16'h1);
		chk(16'(bus_request), 16'h0);
		nmi_clr();
		wait_end(0);
		// nmi in mid-burst stops the engine, unit left uncounted
		setup(0, SRC_AUTO, 1'b1, 16'h100);
		slow <= 1'b0;
		go(0);
		wait_br(1'b1);
		cyc(2);
		nmi_in <= 1'b1;
		cyc(1);
		nmi_in <= 1'b0;
		wait_br(1'b0);
		chk(16'(n <= NMI_STOP_BCYC + NMI_STOP_PCYC * PCLK), 16'h1);
		chk(16'(transfer_end_flag[0]), 16'h0);
		// drop the enable first, or the cut burst restarts once nmi clears
		cyc(1);
		channel_enable_bit <= '0;
		nmi_clr();
		// on-chip ram phase lengths for every clock ratio
		for (int r = 0; r < 4; r++) begin
			setup(0, SRC_AUTO, 1'b0, 16'h1);
			clk_ratio <= 2'(r);
			ch_ram_target[0] <= 1'b1;
			go(0);
			n = 0;
			k = 0;
			repeat (40) begin
				@(posedge core_clk);
				#1 n += 16'(read_active);
				k += 16'(write_active);
			end
			chk(n, rd[r]);
			chk(k, wr[r]);
		end
		// burst holds the bus through all units, ack in write cycles
		setup(0, SRC_AUTO, 1'b1, 16'h3);
		ch_ram_target[0] <= 1'b0;
		clk_ratio <= RATIO_1_2;
		bus_pref_enable <= 1'b1;
		ch_wr_ack_en[0] <= 1'b1;
		go(0);
		wait_br(1'b1);
		k = 0;
		n = 0;
		// one acknowledge cycle per unit, in its single write cycle
		repeat (20) begin
			@(posedge core_clk);
			#1 k += 16'(!bus_request && !transfer_end_flag[0]);
			n += 16'(transfer_ack_out == 4'h1);
		end
		chk(k, 16'h0);
		chk(n, 16'h3);
		chk(16'(transfer_end_flag[0]), 16'h1);
		// level pin going low releases a burst before its count ends
		setup(0, SRC_EXT, 1'b1, 16'h40);
		go(0);
		cyc(1);
		transfer_request_in[0] <= 1'b1;
		wait_br(1'b1);
		cyc(1);
		transfer_request_in[0] <= 1'b0;
		wait_br(1'b0);
		chk(16'(n < 9), 16'h1);
		chk(16'(transfer_end_flag[0]), 16'h0);
		tally_and_finish();
	end
endmodule
